// file: wdt_reset_pkg.sv
// constants, register map and types shared by the watchdog and reset-source unit
package wdt_reset_pkg;

   // register map: byte addresses on the axi4-lite port
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
   localparam logic [ADDR_W-1:0] SHARED_OFFSET = 8'h04;

   // supervision_force_control fields
   localparam int FORCE_BIT = 7;
   localparam int SUP_EN_BIT = 0;
   localparam logic SUP_EN_RESET = 1'b1;

   // reset_cause_status fields
   localparam int ST_TEST_BIT = 7;
   localparam int ST_IDLE_BIT = 6;
   localparam int ST_WAKE_STANDBY_WAKE_FLAG_BIT = 5;
   localparam int ST_FORCED_BIT = 4;
   localparam int ST_CLOCK_BIT = 3;
   localparam int ST_PIN_BIT = 2;
   localparam int ST_SUPPLY_BIT = 1;
   localparam int ST_WDOG_BIT = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // watchdog
   localparam logic [7:0] TIMER_RESET = 8'hFF;
   localparam logic [7:0] WRAP_VALUE = 8'hFF;
   localparam logic [7:0] TIMER_FORBIDDEN = 8'h00;
   localparam logic [7:0] TRIG_RESET = 8'h00;
   localparam int SLOW_DIV = 128;
   localparam logic [6:0] SLOW_PRE_LAST = 7'(SLOW_DIV - 1);

   // reset extension, counted in crystal periods
   localparam int EXT_PERIODS = 2048;
   localparam logic [10:0] EXT_LAST = 11'(EXT_PERIODS - 1);

   // axi4-lite responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {SEQ_TIMER, SEQ_TRIG1, SEQ_TRIG2} wd_seq_e;

endpackage : wdt_reset_pkg

// file: reset_request_extender.sv
// reset request flag with extension timer that delays pin release
`timescale 1ns/1ps
module reset_request_extender (
   input wire logic clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic src_active, // any internal reset source active
   input wire logic xtal_tick, // one pulse per crystal period
   output logic req // reset request, drives the pin low
);

   logic req_ff;
   logic [10:0] cnt_ff;
   logic cnt_done;

   assign cnt_done = (cnt_ff == wdt_reset_pkg::EXT_LAST);
   assign req = req_ff;

   // a source that comes back mid-extension restarts the count from zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         req_ff <= 1'b0;
         cnt_ff <= 11'h000;
      end else if (ce) begin
         if (src_active) begin
            req_ff <= 1'b1;
            cnt_ff <= 11'h000;
         end else if (req_ff && xtal_tick) begin
            if (cnt_done) begin
               req_ff <= 1'b0;
               cnt_ff <= 11'h000;
            end else begin
               cnt_ff <= cnt_ff + 11'h001;
            end
         end
      end
   end

endmodule : reset_request_extender

// file: watchdog_reset_source_unit.sv
// watchdog, forced reset, supervision enable and reset-cause bookkeeping behind axi4-lite
//
// Behaviour
// - Power-on and wake-up resets disable the watchdog; shared write enables it.
// - 8-bit down-counter requests reset, pin low, when wrapping from zero to 0xFF.
// - Shared write reloads counter only if both trigger registers are complementary.
// - Every IC reset loads the watchdog timer register with 0xFF.
// - Counter ticks at base rate in fast modes, base rate divided by 128 in slow.
// - A wrong value in the sequence blocks all further reloads at once.
// - Watchdog flag sets on wrap; cleared only by supply reset or shared write.
// - Writing one to control bit 7 forces the reset pin low; zero does nothing.
// - Entering power saving sets its wake flag; later wake-up pulls the pin low.
// - Low level on reset pin resets the IC; external sources may wire-OR.
// - Control bit 0 resets to one; one enables, zero disables both supervisions.
// - Zero to supervision enable works only after supervision reset, before shared write.
// - Shared read returns test pin, idle, wake, forced, clock, pin, supply, watchdog.
// - Cause flags accumulate since last shared write; that write clears them all.
// - Active-mode resets set pin flag plus watchdog, clock, supply or forced flags.
// - Resets in power saving set clock and pin flags; wake-ups set clock and pin flags too.
// - Internal sources set a request; pin released 2048 crystal periods after they end.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module watchdog_reset_source_unit (
   input wire logic clk, // system clock, 40 MHz
   input wire logic nrst, // async reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic [2:0] s_axi_awprot, // write protection, unused
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic [2:0] s_axi_arprot, // read protection, unused
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   // reset pin, open drain
   input wire logic reset_pin_n_i, // sensed level of the reset pin
   output logic reset_pin_n_o, // driven level, always low
   output logic reset_pin_n_oe, // pull-down active
   output logic sys_reset_n, // system reset to the rest of the IC, active low
   // surroundings
   input wire logic test_pin_level, // test pin level
   input wire logic wdt_tick, // base watchdog clock, one pulse per period
   input wire logic xtal_tick, // one pulse per crystal period
   input wire logic slow_mode, // cpu in a slow mode
   input wire logic in_power_saving, // a power saving mode is active
   input wire logic enter_idle, // pulse: idle mode entered
   input wire logic enter_wake_standby, // pulse: wake or standby mode entered
   input wire logic wake_up, // pulse: wake-up from power saving logic
   input wire logic clock_sup_fail, // clock supervision detects failure
   input wire logic supply_sup_fail, // supply supervision detects failure
   output logic supervision_enable, // clock and supply supervision enabled
   output logic watchdog_enabled // watchdog reset source enabled
);

   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
      addr_is = (addr[7:2] == off[7:2]);
   endfunction : addr_is

   function automatic logic is_complement(input logic [7:0] a, input logic [7:0] b);
      is_complement = ((a ^ b) == 8'hFF);
   endfunction : is_complement

   // ---------------- axi4-lite slave ----------------
   logic aw_have_ff;
   logic w_have_ff;
   logic [7:0] waddr_ff;
   logic [7:0] wdata_ff;
   logic wstrb0_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;

   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire do_write = ce && aw_have_ff && w_have_ff;
   wire w_hit_ctrl = addr_is(waddr_ff, wdt_reset_pkg::CTRL_OFFSET);
   wire w_hit_shared = addr_is(waddr_ff, wdt_reset_pkg::SHARED_OFFSET);
   wire wr_ctrl = do_write && w_hit_ctrl && wstrb0_ff;
   wire wr_shared = do_write && w_hit_shared && wstrb0_ff;
   wire r_hit_ctrl = addr_is(s_axi_araddr, wdt_reset_pkg::CTRL_OFFSET);
   wire r_hit_shared = addr_is(s_axi_araddr, wdt_reset_pkg::SHARED_OFFSET);

   assign s_axi_awready = ce && !aw_have_ff && !bvalid_ff;
   assign s_axi_wready = ce && !w_have_ff && !bvalid_ff;
   assign s_axi_arready = ce && !rvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         waddr_ff <= 8'h00;
         wdata_ff <= 8'h00;
         wstrb0_ff <= 1'b0;
      end else if (ce) begin
         if (aw_fire) begin
            aw_have_ff <= 1'b1;
            waddr_ff <= s_axi_awaddr;
         end else if (do_write) begin
            aw_have_ff <= 1'b0;
         end
         if (w_fire) begin
            w_have_ff <= 1'b1;
            wdata_ff <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_have_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= wdt_reset_pkg::RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (w_hit_ctrl || w_hit_shared) ? wdt_reset_pkg::RESP_OKAY : wdt_reset_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ---------------- reset pin and event sources ----------------
   logic sup_en_ff;
   logic sup_dis_allowed_ff;
   logic wd_en_ff;
   logic req;

   wire ic_reset = !reset_pin_n_i;
   wire supply_evt = supply_sup_fail && sup_en_ff;
   wire clock_evt = clock_sup_fail && sup_en_ff;
   wire forced_evt = wr_ctrl && wdata_ff[wdt_reset_pkg::FORCE_BIT];
   wire wd_wrap;

   // wake-up is one of the five internal sources; entering power saving is not one
   wire src_active = wd_wrap || forced_evt || wake_up || clock_evt || supply_evt;

   reset_request_extender u_ext (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .src_active(src_active),
      .xtal_tick(xtal_tick),
      .req(req)
   );

   // open drain: only ever pulls low, outside sources may wire-or on the same net
   assign reset_pin_n_o = 1'b0;
   assign reset_pin_n_oe = req;
   assign sys_reset_n = reset_pin_n_i;
   assign supervision_enable = sup_en_ff;
   assign watchdog_enabled = wd_en_ff;

   // ---------------- supervision enable ----------------
   wire nxt_allowed = (sup_dis_allowed_ff && !wr_shared) || supply_evt || clock_evt;
   wire wr_sup_one = wr_ctrl && wdata_ff[wdt_reset_pkg::SUP_EN_BIT];
   wire wr_sup_zero = wr_ctrl && !wdata_ff[wdt_reset_pkg::SUP_EN_BIT] && sup_dis_allowed_ff;
   wire nxt_sup_en = wr_sup_one ? 1'b1 : (wr_sup_zero ? 1'b0 : sup_en_ff);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sup_en_ff <= wdt_reset_pkg::SUP_EN_RESET;
         sup_dis_allowed_ff <= 1'b0;
      end else if (ce) begin
         sup_en_ff <= nxt_sup_en;
         sup_dis_allowed_ff <= nxt_allowed;
      end
   end

   // ---------------- watchdog ----------------
   logic [7:0] cnt_ff;
   logic [7:0] timer_ff;
   logic [7:0] trig1_ff;
   logic [7:0] trig2_ff;
   logic have_retrig_ff;
   logic lock_ff;
   logic [6:0] pre_ff;
   wdt_reset_pkg::wd_seq_e seq_ff;

   logic [7:0] nxt_timer;
   logic [7:0] nxt_trig1;
   logic [7:0] nxt_trig2;
   logic nxt_have_retrig;
   logic nxt_lock;
   logic do_reload;
   wdt_reset_pkg::wd_seq_e nxt_seq;

   // prescaler runs only in slow modes, trading resolution for a 128x longer interval
   wire pre_last = (pre_ff == wdt_reset_pkg::SLOW_PRE_LAST);
   wire eff_tick = slow_mode ? (wdt_tick && pre_last) : wdt_tick;
   // a reload landing on the wrap tick keeps the counter from wrapping, so no reset either
   assign wd_wrap = wd_en_ff && eff_tick && !ic_reset && !do_reload && (cnt_ff == 8'h00);

   // power-on and wake-up clear win over the enabling write
   wire nxt_wd_en = (supply_evt || wake_up) ? 1'b0 : (wr_shared ? 1'b1 : wd_en_ff);

   always_comb begin
      nxt_timer = timer_ff;
      nxt_trig1 = trig1_ff;
      nxt_trig2 = trig2_ff;
      nxt_have_retrig = have_retrig_ff;
      nxt_lock = lock_ff;
      nxt_seq = seq_ff;
      do_reload = 1'b0;
      if (wr_shared) begin
         case (seq_ff)
            wdt_reset_pkg::SEQ_TIMER: begin
               nxt_timer = wdata_ff;
               if (wdata_ff == wdt_reset_pkg::TIMER_FORBIDDEN) begin
                  nxt_lock = 1'b1;
               end
               nxt_seq = wdt_reset_pkg::SEQ_TRIG1;
            end
            wdt_reset_pkg::SEQ_TRIG1: begin
               nxt_trig1 = wdata_ff;
               nxt_have_retrig = 1'b1;
               if (have_retrig_ff && (wdata_ff != trig1_ff)) begin
                  nxt_lock = 1'b1;
               end
               nxt_seq = wdt_reset_pkg::SEQ_TRIG2;
            end
            wdt_reset_pkg::SEQ_TRIG2: begin
               nxt_trig2 = wdata_ff;
               if (is_complement(trig1_ff, wdata_ff) && !lock_ff && !nxt_lock) begin
                  do_reload = 1'b1;
               end else begin
                  nxt_lock = 1'b1;
               end
               nxt_seq = wdt_reset_pkg::SEQ_TRIG1;
            end
            default: begin
               nxt_seq = wdt_reset_pkg::SEQ_TIMER;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wd_en_ff <= 1'b0;
      end else if (ce) begin
         wd_en_ff <= nxt_wd_en;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pre_ff <= 7'h00;
      end else if (ce && wdt_tick) begin
         pre_ff <= (slow_mode && !pre_last) ? (pre_ff + 7'h01) : 7'h00;
      end
   end

   // an IC reset reinitialises the sequence and lifts the lock; enable is left alone
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timer_ff <= wdt_reset_pkg::TIMER_RESET;
         trig1_ff <= wdt_reset_pkg::TRIG_RESET;
         trig2_ff <= wdt_reset_pkg::TRIG_RESET;
         have_retrig_ff <= 1'b0;
         lock_ff <= 1'b0;
         seq_ff <= wdt_reset_pkg::SEQ_TIMER;
      end else if (ce) begin
         if (ic_reset) begin
            timer_ff <= wdt_reset_pkg::TIMER_RESET;
            trig1_ff <= wdt_reset_pkg::TRIG_RESET;
            trig2_ff <= wdt_reset_pkg::TRIG_RESET;
            have_retrig_ff <= 1'b0;
            lock_ff <= 1'b0;
            seq_ff <= wdt_reset_pkg::SEQ_TIMER;
         end else begin
            timer_ff <= nxt_timer;
            trig1_ff <= nxt_trig1;
            trig2_ff <= nxt_trig2;
            have_retrig_ff <= nxt_have_retrig;
            lock_ff <= nxt_lock;
            seq_ff <= nxt_seq;
         end
      end
   end

   // reload beats a wrap landing in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= wdt_reset_pkg::TIMER_RESET;
      end else if (ce) begin
         if (ic_reset) begin
            cnt_ff <= wdt_reset_pkg::TIMER_RESET;
         end else if (do_reload) begin
            cnt_ff <= timer_ff;
         end else if (wd_wrap) begin
            cnt_ff <= wdt_reset_pkg::WRAP_VALUE;
         end else if (wd_en_ff && eff_tick) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end

   // ---------------- reset cause flags ----------------
   logic idle_ff;
   logic wake_standby_wake_flag_ff;
   logic forced_ff;
   logic clock_ff;
   logic pin_ff;
   logic supply_ff;
   logic wdog_ff;

   // hardware set wins over the clearing write in the same cycle
   wire set_pin = ic_reset;
   wire set_clock = clock_evt || supply_evt || wake_up || (ic_reset && in_power_saving);
   wire set_supply = supply_evt;
   wire set_forced = forced_evt;
   wire set_wdog = wd_wrap;
   wire set_idle = enter_idle;
   wire set_wake_standby_wake_flag = enter_wake_standby;

   wire nxt_idle = (idle_ff && !wr_shared) || set_idle;
   wire nxt_wake_standby_wake_flag = (wake_standby_wake_flag_ff && !wr_shared) || set_wake_standby_wake_flag;
   wire nxt_forced = (forced_ff && !wr_shared) || set_forced;
   wire nxt_clock = (clock_ff && !wr_shared) || set_clock;
   wire nxt_pin = (pin_ff && !wr_shared) || set_pin;
   wire nxt_supply = (supply_ff && !wr_shared) || set_supply;
   wire nxt_wdog = (wdog_ff && !wr_shared && !supply_evt) || set_wdog;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         idle_ff <= 1'b0;
         wake_standby_wake_flag_ff <= 1'b0;
         forced_ff <= 1'b0;
         clock_ff <= 1'b0;
         pin_ff <= 1'b0;
         supply_ff <= 1'b0;
         wdog_ff <= 1'b0;
      end else if (ce) begin
         idle_ff <= nxt_idle;
         wake_standby_wake_flag_ff <= nxt_wake_standby_wake_flag;
         forced_ff <= nxt_forced;
         clock_ff <= nxt_clock;
         pin_ff <= nxt_pin;
         supply_ff <= nxt_supply;
         wdog_ff <= nxt_wdog;
      end
   end

   // ---------------- read path ----------------
   logic [7:0] status_vec;

   always_comb begin
      status_vec = wdt_reset_pkg::STATUS_RESET;
      status_vec[wdt_reset_pkg::ST_TEST_BIT] = test_pin_level;
      status_vec[wdt_reset_pkg::ST_IDLE_BIT] = idle_ff;
      status_vec[wdt_reset_pkg::ST_WAKE_STANDBY_WAKE_FLAG_BIT] = wake_standby_wake_flag_ff;
      status_vec[wdt_reset_pkg::ST_FORCED_BIT] = forced_ff;
      status_vec[wdt_reset_pkg::ST_CLOCK_BIT] = clock_ff;
      status_vec[wdt_reset_pkg::ST_PIN_BIT] = pin_ff;
      status_vec[wdt_reset_pkg::ST_SUPPLY_BIT] = supply_ff;
      status_vec[wdt_reset_pkg::ST_WDOG_BIT] = wdog_ff;
   end

   // control register is write-only and reads as zero
   wire [31:0] rd_value = r_hit_shared ? {24'h000000, status_vec} : 32'h00000000;
   wire [1:0] rd_resp = (r_hit_ctrl || r_hit_shared) ? wdt_reset_pkg::RESP_OKAY : wdt_reset_pkg::RESP_SLVERR;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= wdt_reset_pkg::RESP_OKAY;
      end else if (ce) begin
         if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_value;
            rresp_ff <= rd_resp;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

endmodule : watchdog_reset_source_unit

// file: wdt_reset_assertions.sv
// concurrent checks on the ports of the watchdog and reset-source unit
`timescale 1ns/1ps
module wdt_reset_assertions (
   input wire logic clk, // clock
   input wire logic nrst, // reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic reset_pin_n_i, // pin level
   input wire logic reset_pin_n_oe, // pin pull-down
   input wire logic sys_reset_n, // system reset
   input wire logic xtal_tick, // crystal tick
   input wire logic wake_up, // wake pulse
   input wire logic supply_sup_fail, // supply failure
   input wire logic supervision_enable, // supervision on
   input wire logic watchdog_enabled // watchdog on
);
   logic [7:0] aw_ff;
   logic [7:0] wd_ff;
   int xt_ff;
   // ticks seen while the pin is pulled; never less than the design's own extension count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_ff <= 8'h00;
         wd_ff <= 8'h00;
         xt_ff <= 0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_ff <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata[7:0];
         xt_ff <= reset_pin_n_oe ? xt_ff + int'(xtal_tick) : 0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_force;
      $rose(s_axi_bvalid) && aw_ff == wdt_reset_pkg::CTRL_OFFSET && wd_ff[7] |-> ##[0:3] reset_pin_n_oe;
   endproperty
   a_force: assert property (p_force) else $error("forced write left the pin released");
   property p_enable;
      $rose(s_axi_bvalid) && aw_ff == wdt_reset_pkg::SHARED_OFFSET
         |-> watchdog_enabled || $past(wake_up) || $past(supply_sup_fail);
   endproperty
   a_enable: assert property (p_enable) else $error("shared write did not enable watchdog");
   property p_wake_off;
      wake_up |=> !watchdog_enabled;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake-up left watchdog enabled");
   property p_wake_pin;
      wake_up |=> reset_pin_n_oe;
   endproperty
   a_wake_pin: assert property (p_wake_pin) else $error("wake-up did not pull the pin");
   property p_supply;
      supply_sup_fail && supervision_enable |-> ##[1:2] reset_pin_n_oe;
   endproperty
   a_supply: assert property (p_supply) else $error("supply failure did not pull the pin");
   property p_sup_change;
      $changed(supervision_enable) |-> $rose(s_axi_bvalid) && aw_ff == wdt_reset_pkg::CTRL_OFFSET;
   endproperty
   a_sup_change: assert property (p_sup_change) else $error("supervision enable changed without a write");
   property p_release;
      $fell(reset_pin_n_oe) |-> xt_ff >= wdt_reset_pkg::EXT_PERIODS;
   endproperty
   a_release: assert property (p_release) else $error("pin released before the extension ran out");
   property p_sys;
      sys_reset_n == reset_pin_n_i;
   endproperty
   a_sys: assert property (p_sys) else $error("system reset does not follow the pin");
   c_release: cover property ($fell(reset_pin_n_oe));
   c_wake: cover property (wake_up);
   c_shared: cover property ($rose(s_axi_bvalid) && aw_ff == wdt_reset_pkg::SHARED_OFFSET);
endmodule : wdt_reset_assertions

bind watchdog_reset_source_unit wdt_reset_assertions u_wdt_reset_assertions (.clk(clk), .nrst(nrst),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .reset_pin_n_i(reset_pin_n_i), .reset_pin_n_oe(reset_pin_n_oe),
   .sys_reset_n(sys_reset_n), .xtal_tick(xtal_tick), .wake_up(wake_up), .supply_sup_fail(supply_sup_fail),
   .supervision_enable(supervision_enable), .watchdog_enabled(watchdog_enabled));

// file: testbench.sv
// self-checking bench for the watchdog and reset-source unit
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] SH = wdt_reset_pkg::SHARED_OFFSET;
   localparam logic [7:0] CT = wdt_reset_pkg::CTRL_OFFSET;
   localparam logic [1:0] OK = wdt_reset_pkg::RESP_OKAY;
   logic clk, nrst, awvalid, wvalid, bvalid, arvalid, rvalid, awready, wready, arready;
   logic oe, pin_o, pin, sys_n, sup_en, wd_en, xtal, wdt_tick, test_pin, slow;
   logic [7:0] awaddr, araddr, r, t;
   logic [2:0] prot;
   logic [3:0] strb;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [5:0] ev;
   logic [5:0] evs [5] = '{6'h01, 6'h02, 6'h08, 6'h14, 6'h20};
   logic [6:0] exps [5] = '{7'h0C, 7'h0E, 7'h40, 7'h4C, 7'h20};
   int err_count, comparisons, seed, i;
   // open drain: only the pull-down of the unit acts on the pin
   assign pin = oe ? pin_o : 1'b1;
   watchdog_reset_source_unit u_watchdog_reset_source_unit (.clk(clk), .nrst(nrst), .ce(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .reset_pin_n_i(pin),
      .reset_pin_n_o(pin_o), .reset_pin_n_oe(oe), .sys_reset_n(sys_n), .test_pin_level(test_pin),
      .wdt_tick(wdt_tick), .xtal_tick(xtal), .slow_mode(slow), .in_power_saving(ev[4]),
      .enter_idle(ev[3]), .enter_wake_standby(ev[5]), .wake_up(ev[2]), .clock_sup_fail(ev[0]),
      .supply_sup_fail(ev[1]), .supervision_enable(sup_en), .watchdog_enabled(wd_en));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) xtal <= 1'($random(seed));
   function logic [31:0] st(input logic [6:0] f);
      return {24'h000000, test_pin, f};
   endfunction : st
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task end_sim;
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   task tmo;
      err_count++;
      $display("MISMATCH %0t wait ran out", $time);
      end_sim();
   endtask : tmo
   task wr(input logic [7:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'($random(seed)), d};
      strb <= 4'($random(seed)) | 4'h1;
      prot <= 3'($random(seed));
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 100) tmo();
      chk(32'(bresp), 32'(a == CT || a == SH ? OK : wdt_reset_pkg::RESP_SLVERR));
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] exp);
      araddr <= a;
      prot <= 3'($random(seed));
      arvalid <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 100) tmo();
      chk(rdata, exp);
      chk(32'(rresp), 32'(a == CT || a == SH ? OK : wdt_reset_pkg::RESP_SLVERR));
   endtask : rd
   // waits up to n cycles for the pull-down, then for its release
   task rel(input logic e, input int n);
      for (i = 0; i < n && !oe; i++) @(posedge clk);
      chk(32'(oe), 32'(e));
      for (i = 0; i < 9000 && oe; i++) @(posedge clk);
      if (oe) tmo();
   endtask : rel
   initial begin
      seed = 32'h261B;
      {nrst, awvalid, wvalid, arvalid, wdt_tick, slow, prot, ev} = '0;
      {awaddr, araddr, wdata, strb} = '0;
      err_count = 0;
      comparisons = 0;
      test_pin = 1'($random(seed));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk(32'({oe, sup_en, wd_en}), 32'h2);
      rd(SH, st(7'h00));
      rd(CT, 32'h0);
      rd(8'h0C, 32'h0);
      wr(8'h48, 8'h55);
      wr(CT, 8'h00);
      chk(32'(sup_en), 32'h1);
      for (int j = 0; j < 5; j++) begin
         ev <= evs[j];
         @(posedge clk);
         ev <= 6'h00;
         rel(j != 2 && j != 4, 40);
         rd(SH, st(exps[j]));
         if (j == 3) chk(32'(wd_en), 32'h0);
         if (j == 1) begin
            wr(CT, 8'h00);
            chk(32'(sup_en), 32'h0);
            wr(CT, 8'h01);
            chk(32'(sup_en), 32'h1);
         end
         if (j != 2) wr(SH, 8'($random(seed)) | 8'h01);
      end
      wr(CT, 8'h81);
      rel(1'b1, 40);
      rd(SH, st(7'h14));
      t = 8'h28 + 8'($unsigned($random(seed)) % 60);
      r = 8'($random(seed));
      wr(SH, t);
      chk(32'(wd_en), 32'h1);
      wdt_tick <= 1'b1;
      // more than 256 ticks, so a counter that is never reloaded would have wrapped
      repeat (50) begin
         wr(SH, r);
         wr(SH, ~r);
      end
      chk(32'(oe), 32'h0);
      wr(SH, r ^ 8'h10);
      repeat (30) begin
         wr(SH, r);
         wr(SH, ~r);
      end
      chk(32'(oe), 32'h1);
      rel(1'b1, 40);
      rel(1'b1, 400);
      rd(SH, st(7'h05));
      // slow mode: timer 1 gives two ticks of 128 base periods each
      slow <= 1'b1;
      wr(SH, 8'h01);
      wr(SH, r);
      wr(SH, ~r);
      rel(1'b0, 120);
      rel(1'b1, 200);
      rd(SH, st(7'h05));
      {slow, wdt_tick} <= 2'b00;
      end_sim();
   end
endmodule : testbench
